// File: pliu_top.sv
// Four-level priority interrupt and level switching unit
`timescale 1ns/1ns
`include "pliu_defines.svh"
module pliu_top #(
    parameter int N_DEV = 16
) (
    input  wire logic                      CLK_IN,
    input  wire logic                      RESET_N_IN,
    input  wire logic                      CE_IN,
    input  wire logic [3:0]                AVS_ADDRESS_IN,
    input  wire logic                      AVS_READ_IN,
    input  wire logic                      AVS_WRITE_IN,
    input  wire logic [31:0]               AVS_WRITEDATA_IN,
    output logic      [31:0]               AVS_READDATA_OUT,
    output logic                           AVS_WAITREQUEST_OUT,
    input  wire logic                      INSTR_BOUNDARY_IN,
    input  wire logic                      EXIT_IN,
    input  wire logic                      SETLVL_IN,
    input  wire logic [`PLIU_LVL_W-1:0]    SETLVL_SEL_IN,
    input  wire logic                      STOP_IN,
    input  wire logic                      IPL_DONE_IN,
    input  wire logic                      CLASS_REQ_IN,
    input  wire logic [2:0]                CLASS_SEL_IN,
    input  wire logic [`PLIU_RF_IDX_W-1:0] CORE_REG_SEL_IN,
    input  wire logic                      CORE_REG_WE_IN,
    input  wire logic [`PLIU_WORD_W-1:0]   CORE_REG_WDATA_IN,
    output logic      [`PLIU_WORD_W-1:0]   CORE_REG_RDATA_OUT,
    input  wire logic [N_DEV-1:0]          DEV_REQ_IN,
    input  wire logic                      DEV_ID_VALID_IN,
    input  wire logic [`PLIU_WORD_W-1:0]   DEV_ID_WORD_IN,
    output logic                           INT_ACK_OUT,
    output logic      [`PLIU_DEV_W-1:0]    INT_ACK_DEV_OUT,
    output logic                           MEM_RD_OUT,
    output logic      [`PLIU_WORD_W-1:0]   MEM_ADDR_OUT,
    input  wire logic                      MEM_VALID_IN,
    input  wire logic [`PLIU_WORD_W-1:0]   MEM_RDATA_IN,
    output logic      [`PLIU_NUM_LEVELS-1:0] ACTIVE_LEVELS_OUT,
    output logic      [`PLIU_LVL_W-1:0]    CUR_LEVEL_OUT,
    output logic                           WAIT_OUT,
    output logic                           BUSY_OUT,
    output logic      [`PLIU_WORD_W-1:0]   CLASS_LSB_PTR_OUT
);
    if (N_DEV < 1 || N_DEV > `PLIU_MAX_DEV) begin : g_bad_ndev
        $error("N_DEV must lie between 1 and 256");
    end

    // Lowest set bit, i.e. most urgent level
    function automatic logic [`PLIU_LVL_W-1:0] first_level(input logic [3:0] v);
        logic [`PLIU_LVL_W-1:0] r;
        r = 2'h3;
        if (v[2]) r = 2'h2;
        if (v[1]) r = 2'h1;
        if (v[0]) r = 2'h0;
        return r;
    endfunction

    // Synchronisers for device pins
    logic [N_DEV-1:0]          req_s1_r;
    logic [N_DEV-1:0]          req_s2_r;
    logic                      idv_s1_r;
    logic                      idv_s2_r;
    logic [`PLIU_WORD_W-1:0]   idw_s1_r;
    logic [`PLIU_WORD_W-1:0]   idw_s2_r;

    pliu_pkg::pliu_state_t     state_r;
    pliu_pkg::pliu_state_t     state_nxt;
    logic [3:0]                active_r;
    logic [3:0]                active_nxt;
    logic [`PLIU_LVL_W-1:0]    tgt_lvl_r;
    logic [`PLIU_LVL_W-1:0]    tgt_lvl_nxt;
    logic [`PLIU_DEV_W-1:0]    ack_dev_r;
    logic [`PLIU_DEV_W-1:0]    ack_dev_nxt;
    logic                      ack_r;
    logic                      ack_nxt;
    logic                      mem_rd_r;
    logic                      mem_rd_nxt;
    logic [`PLIU_WORD_W-1:0]   mem_addr_r;
    logic [`PLIU_WORD_W-1:0]   mem_addr_nxt;
    logic [`PLIU_WORD_W-1:0]   lsb_ptr_r;
    logic [`PLIU_LVL_W-1:0]    cur_out_r;
    logic                      wait_r;
    logic                      busy_r;
    logic [31:0]               ctrl_r;
    logic                      waitreq_r;
    logic [31:0]               rdata_r;
    logic [31:0]               rdata_nxt;
    logic                      dev_mask_r [N_DEV];
    logic [3:0]                dev_lvl_r  [N_DEV];
    logic [N_DEV-1:0]          dev_elig;
    logic [3:0]                pend_lvl;
    logic [`PLIU_DEV_W-1:0]    sel_dev;
    logic                      rf_we;
    logic [`PLIU_RF_AW-1:0]    rf_waddr;
    logic [`PLIU_WORD_W-1:0]   rf_wdata;

    // Decoding and selection
    wire                          is_wait    = (active_r == `PLIU_ACTIVE_RESET);
    wire [`PLIU_LVL_W-1:0]        cur_lvl    = first_level(active_r);
    wire                          idle       = (state_r == pliu_pkg::ST_IDLE);
    wire                          summary_on = ctrl_r[`PLIU_CTRL_SUM_BIT];
    wire [3:0]                    lvl_mask   = ctrl_r[`PLIU_CTRL_LMASK_MSB:`PLIU_CTRL_LMASK_LSB];
    wire                          eval       = idle & (INSTR_BOUNDARY_IN | is_wait);
    wire                          ctl_go     = idle & INSTR_BOUNDARY_IN & (EXIT_IN | SETLVL_IN);
    wire                          cls_masked = ~summary_on &
                                  ((CLASS_SEL_IN == pliu_pkg::CL_POWER) |
                                   (CLASS_SEL_IN == pliu_pkg::CL_CONSOLE));
    wire                          class_go   = eval & ~ctl_go & CLASS_REQ_IN & ~cls_masked;
    wire [`PLIU_LVL_W-1:0]        best_lvl   = first_level(pend_lvl);
    wire                          io_go      = eval & ~ctl_go & ~class_go & summary_on &
                                  ~STOP_IN & (|pend_lvl) &
                                  (is_wait | (best_lvl < cur_lvl));
    wire                          bus_req    = AVS_READ_IN | AVS_WRITE_IN;
    wire                          bus_done   = bus_req & ~waitreq_r;
    wire                          bus_wr     = bus_done & AVS_WRITE_IN;
    wire [`PLIU_DEV_W-1:0]        prep_dev   =
                                  AVS_WRITEDATA_IN[`PLIU_PREP_DEV_MSB:`PLIU_PREP_DEV_LSB];
    wire                          prep_wr    = bus_wr & (AVS_ADDRESS_IN == `PLIU_OFS_PREPARE);
    wire [`PLIU_WORD_W-1:0]       dev_vec    = 16'(`PLIU_DEV_VEC_BASE +
                                  {7'h00, ack_dev_r, 1'b0});
    wire [`PLIU_WORD_W-1:0]       cls_vec    = 16'(`PLIU_CLASS_VEC_BASE +
                                  {11'h000, CLASS_SEL_IN, 2'h0});
    wire [`PLIU_RF_AW-1:0]        rf_raddr   = {cur_lvl, CORE_REG_SEL_IN};

    // Per-device eligibility and prepare registers
    for (genvar g = 0; g < N_DEV; g++) begin : g_dev
        assign dev_elig[g] = req_s2_r[g] & dev_mask_r[g] &
                             (dev_lvl_r[g][3:2] == 2'h0) &
                             lvl_mask[dev_lvl_r[g][1:0]];
        always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
            if (!RESET_N_IN) begin
                dev_mask_r[g] <= 1'b0;
                dev_lvl_r[g]  <= 4'h0;
            end else if (CE_IN && prep_wr && prep_dev == 8'(g)) begin
                dev_mask_r[g] <= AVS_WRITEDATA_IN[`PLIU_PREP_MASK_BIT];
                dev_lvl_r[g]  <= AVS_WRITEDATA_IN[`PLIU_PREP_LVL_MSB:`PLIU_PREP_LVL_LSB];
            end
        end
    end

    // Pending levels and most urgent device on best level
    always_comb begin
        pend_lvl = 4'h0;
        sel_dev  = 8'h00;
        for (int d = 0; d < N_DEV; d++) begin
            if (dev_elig[d]) pend_lvl[dev_lvl_r[d][1:0]] = 1'b1;
        end
        for (int d = N_DEV - 1; d >= 0; d--) begin
            if (dev_elig[d] && dev_lvl_r[d][1:0] == best_lvl) sel_dev = 8'(d);
        end
    end

    // Level activity
    always_comb begin
        active_nxt = active_r;
        if (IPL_DONE_IN) begin
            active_nxt = `PLIU_ACTIVE_IPL;
        end else if (ctl_go) begin
            if (!is_wait) active_nxt[cur_lvl] = 1'b0;
            if (SETLVL_IN) active_nxt[SETLVL_SEL_IN] = 1'b1;
        end else if (class_go && is_wait) begin
            active_nxt[0] = 1'b1;
        end else if (state_r == pliu_pkg::ST_ENT_RD && MEM_VALID_IN) begin
            active_nxt[tgt_lvl_r] = 1'b1;
        end
    end

    // Sequencer
    always_comb begin
        state_nxt    = state_r;
        tgt_lvl_nxt  = tgt_lvl_r;
        ack_dev_nxt  = ack_dev_r;
        ack_nxt      = ack_r;
        mem_rd_nxt   = mem_rd_r;
        mem_addr_nxt = mem_addr_r;
        case (state_r)
            pliu_pkg::ST_IDLE: begin
                if (class_go) begin
                    tgt_lvl_nxt  = is_wait ? 2'h0 : cur_lvl;
                    mem_rd_nxt   = 1'b1;
                    mem_addr_nxt = cls_vec;
                    state_nxt    = pliu_pkg::ST_CL_PTR;
                end else if (io_go) begin
                    tgt_lvl_nxt = best_lvl;
                    ack_dev_nxt = sel_dev;
                    ack_nxt     = 1'b1;
                    state_nxt   = pliu_pkg::ST_ID_WAIT;
                end
            end
            pliu_pkg::ST_ID_WAIT: begin
                if (idv_s2_r) begin
                    ack_nxt      = 1'b0;
                    mem_rd_nxt   = 1'b1;
                    mem_addr_nxt = dev_vec;
                    state_nxt    = pliu_pkg::ST_PTR_RD;
                end
            end
            pliu_pkg::ST_PTR_RD: begin
                if (MEM_VALID_IN) begin
                    mem_addr_nxt = MEM_RDATA_IN;
                    state_nxt    = pliu_pkg::ST_ENT_RD;
                end
            end
            pliu_pkg::ST_ENT_RD: begin
                if (MEM_VALID_IN) begin
                    mem_rd_nxt = 1'b0;
                    state_nxt  = pliu_pkg::ST_IDLE;
                end
            end
            pliu_pkg::ST_CL_PTR: begin
                if (MEM_VALID_IN) begin
                    mem_addr_nxt = 16'(mem_addr_r + `PLIU_WORD_BYTES);
                    state_nxt    = pliu_pkg::ST_CL_SIA;
                end
            end
            pliu_pkg::ST_CL_SIA: begin
                if (MEM_VALID_IN) begin
                    mem_rd_nxt = 1'b0;
                    state_nxt  = pliu_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = pliu_pkg::ST_IDLE;
            end
        endcase
        if (IPL_DONE_IN) begin
            state_nxt  = pliu_pkg::ST_IDLE;
            ack_nxt    = 1'b0;
            mem_rd_nxt = 1'b0;
        end
    end

    // Register-set write port
    always_comb begin
        rf_we    = 1'b0;
        rf_waddr = {cur_lvl, CORE_REG_SEL_IN};
        rf_wdata = CORE_REG_WDATA_IN;
        if (IPL_DONE_IN) begin
            rf_we    = 1'b1;
            rf_waddr = {2'h0, `PLIU_REG_IPR};
            rf_wdata = `PLIU_RESTART_ADDR;
        end else if (state_r == pliu_pkg::ST_ID_WAIT && idv_s2_r) begin
            rf_we    = 1'b1;
            rf_waddr = {tgt_lvl_r, `PLIU_REG_R7};
            rf_wdata = idw_s2_r;
        end else if (state_r == pliu_pkg::ST_PTR_RD && MEM_VALID_IN) begin
            rf_we    = 1'b1;
            rf_waddr = {tgt_lvl_r, `PLIU_REG_R1};
            rf_wdata = MEM_RDATA_IN;
        end else if ((state_r == pliu_pkg::ST_ENT_RD || state_r == pliu_pkg::ST_CL_SIA) &&
                     MEM_VALID_IN) begin
            rf_we    = 1'b1;
            rf_waddr = {tgt_lvl_r, `PLIU_REG_IPR};
            rf_wdata = MEM_RDATA_IN;
        end else if (idle && CORE_REG_WE_IN) begin
            rf_we = 1'b1;
        end
    end

    // Bus read selection
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (AVS_ADDRESS_IN)
            `PLIU_OFS_CTRL:   rdata_nxt = ctrl_r;
            `PLIU_OFS_STATUS: rdata_nxt = {24'h000000, busy_r, cur_out_r, wait_r, active_r};
            default:          rdata_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            req_s1_r <= '0;
            req_s2_r <= '0;
            idv_s1_r <= 1'b0;
            idv_s2_r <= 1'b0;
            idw_s1_r <= 16'h0000;
            idw_s2_r <= 16'h0000;
        end else if (CE_IN) begin
            req_s1_r <= DEV_REQ_IN;
            req_s2_r <= req_s1_r;
            idv_s1_r <= DEV_ID_VALID_IN;
            idv_s2_r <= idv_s1_r;
            idw_s1_r <= DEV_ID_WORD_IN;
            idw_s2_r <= idw_s1_r;
        end
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            state_r    <= pliu_pkg::ST_IDLE;
            active_r   <= `PLIU_ACTIVE_RESET;
            tgt_lvl_r  <= 2'h0;
            ack_dev_r  <= 8'h00;
            ack_r      <= 1'b0;
            mem_rd_r   <= 1'b0;
            mem_addr_r <= 16'h0000;
        end else if (CE_IN) begin
            state_r    <= state_nxt;
            active_r   <= active_nxt;
            tgt_lvl_r  <= tgt_lvl_nxt;
            ack_dev_r  <= ack_dev_nxt;
            ack_r      <= ack_nxt;
            mem_rd_r   <= mem_rd_nxt;
            mem_addr_r <= mem_addr_nxt;
        end
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            lsb_ptr_r <= 16'h0000;
            cur_out_r <= 2'h0;
            wait_r    <= 1'b1;
            busy_r    <= 1'b0;
        end else if (CE_IN) begin
            if (state_r == pliu_pkg::ST_CL_PTR && MEM_VALID_IN) lsb_ptr_r <= MEM_RDATA_IN;
            cur_out_r <= first_level(active_nxt);
            wait_r    <= (active_nxt == `PLIU_ACTIVE_RESET);
            busy_r    <= (state_nxt != pliu_pkg::ST_IDLE);
        end
    end

    // Avalon slave, one wait cycle per access
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            ctrl_r    <= `PLIU_CTRL_RESET;
            waitreq_r <= 1'b1;
            rdata_r   <= 32'h0000_0000;
        end else if (CE_IN) begin
            waitreq_r <= ~(bus_req & waitreq_r);
            if (bus_req && waitreq_r) rdata_r <= rdata_nxt;
            if (bus_wr && AVS_ADDRESS_IN == `PLIU_OFS_CTRL) begin
                ctrl_r <= {24'h000000,
                           AVS_WRITEDATA_IN[`PLIU_CTRL_LMASK_MSB:`PLIU_CTRL_LMASK_LSB],
                           3'h0, AVS_WRITEDATA_IN[`PLIU_CTRL_SUM_BIT]};
            end
        end
    end

    pliu_regfile #(
        .DW (`PLIU_WORD_W),
        .AW (`PLIU_RF_AW)
    ) u_regfile (
        .clk_in     (CLK_IN),
        .reset_n_in (RESET_N_IN),
        .en_in      (CE_IN),
        .we_in      (rf_we),
        .waddr_in   (rf_waddr),
        .wdata_in   (rf_wdata),
        .raddr_in   (rf_raddr),
        .rdata_out  (CORE_REG_RDATA_OUT)
    );

    assign AVS_READDATA_OUT    = rdata_r;
    assign AVS_WAITREQUEST_OUT = waitreq_r;
    assign INT_ACK_OUT         = ack_r;
    assign INT_ACK_DEV_OUT     = ack_dev_r;
    assign MEM_RD_OUT          = mem_rd_r;
    assign MEM_ADDR_OUT        = mem_addr_r;
    assign ACTIVE_LEVELS_OUT   = active_r;
    assign CUR_LEVEL_OUT       = cur_out_r;
    assign WAIT_OUT            = wait_r;
    assign BUSY_OUT            = busy_r;
    assign CLASS_LSB_PTR_OUT   = lsb_ptr_r;
endmodule // pliu_top

// File: pliu_defines.svh
// Constants of the priority level interrupt unit
`ifndef PLIU_DEFINES_SVH
`define PLIU_DEFINES_SVH

`define PLIU_NUM_LEVELS      4
`define PLIU_LVL_W           2
`define PLIU_DEV_W           8
`define PLIU_MAX_DEV         256
`define PLIU_WORD_W          16
`define PLIU_RF_AW           6
`define PLIU_RF_IDX_W        4

`define PLIU_DEV_VEC_BASE    16'h0030
`define PLIU_CLASS_VEC_BASE  16'h0008
`define PLIU_RESTART_ADDR    16'h0000
`define PLIU_WORD_BYTES      16'h0002

`define PLIU_REG_R1          4'h1
`define PLIU_REG_R7          4'h7
`define PLIU_REG_STS         4'h8
`define PLIU_REG_IPR         4'h9

`define PLIU_OFS_CTRL        4'h0
`define PLIU_OFS_STATUS      4'h4
`define PLIU_OFS_PREPARE     4'h8

`define PLIU_CTRL_SUM_BIT    0
`define PLIU_CTRL_LMASK_LSB  4
`define PLIU_CTRL_LMASK_MSB  7

`define PLIU_PREP_MASK_BIT   0
`define PLIU_PREP_LVL_LSB    1
`define PLIU_PREP_LVL_MSB    4
`define PLIU_PREP_DEV_LSB    16
`define PLIU_PREP_DEV_MSB    23

`define PLIU_CTRL_RESET      32'h0000_0000
`define PLIU_ACTIVE_RESET    4'h0
`define PLIU_ACTIVE_IPL      4'h1

`endif

// File: pliu_pkg.sv
// Types of the priority level interrupt unit
package pliu_pkg;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_ID_WAIT = 3'h1,
        ST_PTR_RD  = 3'h3,
        ST_ENT_RD  = 3'h2,
        ST_CL_PTR  = 3'h4,
        ST_CL_SIA  = 3'h5
    } pliu_state_t;

    typedef enum logic [2:0] {
        CL_MACHINE = 3'h0,
        CL_PROGRAM = 3'h1,
        CL_CALL    = 3'h2,
        CL_POWER   = 3'h3,
        CL_TRACE   = 3'h4,
        CL_CONSOLE = 3'h5,
        CL_SOFT    = 3'h6
    } pliu_class_t;

endpackage

// File: pliu_regfile.sv
// Per-level register sets with a registered read port
`timescale 1ns/1ns
module pliu_regfile #(
    parameter int DW = 16,
    parameter int AW = 6
) (
    input  wire logic          clk_in,
    input  wire logic          reset_n_in,
    input  wire logic          en_in,
    input  wire logic          we_in,
    input  wire logic [AW-1:0] waddr_in,
    input  wire logic [DW-1:0] wdata_in,
    input  wire logic [AW-1:0] raddr_in,
    output logic      [DW-1:0] rdata_out
);
    logic [DW-1:0] mem_r [2**AW];

    always_ff @(posedge clk_in) begin
        if (en_in && we_in) begin
            mem_r[waddr_in] <= wdata_in;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_out <= '0;
        end else if (en_in) begin
            rdata_out <= mem_r[raddr_in];
        end
    end
endmodule // pliu_regfile

// File: pliu_top_props.sv
// Concurrent checks on the interrupt unit ports
`timescale 1ns/1ns
module pliu_top_props (
    input wire logic        CLK_IN,
    input wire logic        RESET_N_IN,
    input wire logic        AVS_READ_IN,
    input wire logic        AVS_WRITE_IN,
    input wire logic        AVS_WAITREQUEST_OUT,
    input wire logic        INSTR_BOUNDARY_IN,
    input wire logic        EXIT_IN,
    input wire logic        SETLVL_IN,
    input wire logic        STOP_IN,
    input wire logic        IPL_DONE_IN,
    input wire logic        CLASS_REQ_IN,
    input wire logic [2:0]  CLASS_SEL_IN,
    input wire logic        DEV_ID_VALID_IN,
    input wire logic        INT_ACK_OUT,
    input wire logic [7:0]  INT_ACK_DEV_OUT,
    input wire logic        MEM_RD_OUT,
    input wire logic [15:0] MEM_ADDR_OUT,
    input wire logic        MEM_VALID_IN,
    input wire logic [3:0]  ACTIVE_LEVELS_OUT,
    input wire logic [1:0]  CUR_LEVEL_OUT,
    input wire logic        WAIT_OUT,
    input wire logic        BUSY_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESET_N_IN);
    sequence s_exit;
        EXIT_IN && INSTR_BOUNDARY_IN && !BUSY_OUT && !SETLVL_IN;
    endsequence
    sequence s_ack_end;
        INT_ACK_OUT ##1 !INT_ACK_OUT;
    endsequence
    AST_BUS_ANSWER: assert property ((AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT
        |=> !AVS_WAITREQUEST_OUT) else $error("bus late");
    AST_WAIT_STATE: assert property (WAIT_OUT == (ACTIVE_LEVELS_OUT == 4'h0))
        else $error("wait flag");
    AST_CUR_LEVEL: assert property (!WAIT_OUT |-> CUR_LEVEL_OUT ==
        (ACTIVE_LEVELS_OUT[0] ? 2'h0 : ACTIVE_LEVELS_OUT[1] ? 2'h1 :
        ACTIVE_LEVELS_OUT[2] ? 2'h2 : 2'h3)) else $error("cur level");
    AST_ACK_CAUSE: assert property ($rose(INT_ACK_OUT) |->
        !$past(STOP_IN) && !$past(BUSY_OUT)) else $error("bad accept");
    AST_ACK_HOLD: assert property (INT_ACK_OUT && !DEV_ID_VALID_IN |=> INT_ACK_OUT)
        else $error("ack early");
    AST_DEV_VECTOR: assert property (s_ack_end |-> MEM_RD_OUT &&
        MEM_ADDR_OUT == 16'h0030 + {7'h00, INT_ACK_DEV_OUT, 1'b0}) else $error("dev vector");
    AST_MEM_HOLD: assert property (MEM_RD_OUT && !MEM_VALID_IN |=> MEM_RD_OUT &&
        $stable(MEM_ADDR_OUT)) else $error("mem hold");
    AST_EXIT_WAIT: assert property (s_exit ##0 $onehot(ACTIVE_LEVELS_OUT) |->
        ##[1:2] WAIT_OUT) else $error("exit wait");
    AST_CLASS_WAIT: assert property (CLASS_REQ_IN && WAIT_OUT && !BUSY_OUT && !EXIT_IN &&
        !SETLVL_IN && CLASS_SEL_IN == 3'h0 |-> ##[1:2] ACTIVE_LEVELS_OUT == 4'h1)
        else $error("class level");
    AST_IPL_LEVEL0: assert property (IPL_DONE_IN |-> ##[1:2] ACTIVE_LEVELS_OUT[0])
        else $error("load level");
endmodule // pliu_top_props
bind pliu_top pliu_top_props u_props (
    .CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .AVS_READ_IN(AVS_READ_IN),
    .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
    .INSTR_BOUNDARY_IN(INSTR_BOUNDARY_IN), .EXIT_IN(EXIT_IN), .SETLVL_IN(SETLVL_IN),
    .STOP_IN(STOP_IN), .IPL_DONE_IN(IPL_DONE_IN), .CLASS_REQ_IN(CLASS_REQ_IN),
    .CLASS_SEL_IN(CLASS_SEL_IN), .DEV_ID_VALID_IN(DEV_ID_VALID_IN), .INT_ACK_OUT(INT_ACK_OUT),
    .INT_ACK_DEV_OUT(INT_ACK_DEV_OUT), .MEM_RD_OUT(MEM_RD_OUT), .MEM_ADDR_OUT(MEM_ADDR_OUT),
    .MEM_VALID_IN(MEM_VALID_IN), .ACTIVE_LEVELS_OUT(ACTIVE_LEVELS_OUT),
    .CUR_LEVEL_OUT(CUR_LEVEL_OUT), .WAIT_OUT(WAIT_OUT), .BUSY_OUT(BUSY_OUT));

// File: pliu_dev_model.sv
// Device and storage partner of the interrupt unit
`timescale 1ns/1ns
module pliu_dev_model (
    input  wire logic [15:0] raise_in,
    input  wire logic        clk_in,
    input  wire logic [3:0]  lat_in,
    input  wire logic        ack_in,
    input  wire logic [7:0]  ack_dev_in,
    input  wire logic        mem_rd_in,
    input  wire logic [15:0] mem_addr_in,
    output logic      [15:0] req_out,
    output logic             id_valid_out,
    output logic      [15:0] id_word_out,
    output logic             mem_valid_out,
    output logic      [15:0] mem_rdata_out
);
    logic [3:0] cnt_r;
    logic       ack_r;
    initial begin
        {req_out, id_valid_out, id_word_out, mem_valid_out, mem_rdata_out, cnt_r, ack_r} = '0;
    end
    always @(posedge clk_in) begin
        ack_r <= ack_in;
        req_out <= req_out | raise_in;
        if (ack_in) begin
            id_valid_out <= 1'b1;
            id_word_out <= {8'ha5, ack_dev_in};
        end else if (ack_r) begin
            id_valid_out <= 1'b0;
            id_word_out <= ~id_word_out;
            req_out[ack_dev_in[3:0]] <= 1'b0;
        end
        mem_valid_out <= 1'b0;
        if (mem_valid_out)
            mem_rdata_out <= ~mem_rdata_out;
        if (mem_rd_in && !mem_valid_out) begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r >= lat_in) begin
                mem_valid_out <= 1'b1;
                mem_rdata_out <= mem_addr_in + 16'h1000;
                cnt_r <= 4'h0;
            end
        end
    end
endmodule // pliu_dev_model

// File: pliu_top_bench.sv
// Self-checking bench of the interrupt unit
`timescale 1ns/1ns
module pliu_top_bench;
    logic        clk, rst_n, rd, wr, bnd, ext, setl, stop, ipl, creq, wreq, idv, ack, mrd, mv;
    logic        wt, busy;
    logic [1:0]  sl, cur;
    logic [2:0]  csel;
    logic [3:0]  adr, rsel, lat, act;
    logic [7:0]  ackd;
    logic [15:0] rs, rrd, dreq, idw, madr, mdat, cptr;
    logic [31:0] wd, rdat, q;
    int          n_mismatch, n_tests;
    pliu_top dut_u (.CLK_IN(clk), .RESET_N_IN(rst_n), .CE_IN(1'b1), .AVS_ADDRESS_IN(adr),
        .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_READDATA_OUT(rdat),
        .AVS_WAITREQUEST_OUT(wreq), .INSTR_BOUNDARY_IN(bnd), .EXIT_IN(ext), .SETLVL_IN(setl),
        .SETLVL_SEL_IN(sl), .STOP_IN(stop), .IPL_DONE_IN(ipl), .CLASS_REQ_IN(creq),
        .CLASS_SEL_IN(csel), .CORE_REG_SEL_IN(rsel), .CORE_REG_WE_IN(1'b0),
        .CORE_REG_WDATA_IN(16'h0), .CORE_REG_RDATA_OUT(rrd), .DEV_REQ_IN(dreq),
        .DEV_ID_VALID_IN(idv), .DEV_ID_WORD_IN(idw), .INT_ACK_OUT(ack), .INT_ACK_DEV_OUT(ackd),
        .MEM_RD_OUT(mrd), .MEM_ADDR_OUT(madr), .MEM_VALID_IN(mv), .MEM_RDATA_IN(mdat),
        .ACTIVE_LEVELS_OUT(act), .CUR_LEVEL_OUT(cur), .WAIT_OUT(wt), .BUSY_OUT(busy),
        .CLASS_LSB_PTR_OUT(cptr));
    pliu_dev_model partner_u (.clk_in(clk), .raise_in(rs), .lat_in(lat), .ack_in(ack),
        .ack_dev_in(ackd), .mem_rd_in(mrd), .mem_addr_in(madr), .req_out(dreq),
        .id_valid_out(idv), .id_word_out(idw), .mem_valid_out(mv), .mem_rdata_out(mdat));
    always #5 clk = ~clk;
    task print_verdict;
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task prep(input logic [7:0] dev, input logic [3:0] lvl, input logic m);
        bus(1'b1, 4'h8, {8'h00, dev, 11'h000, lvl, m});
    endtask
    task rreg(input logic [3:0] s, input logic [15:0] e);
        @(posedge clk);
        rsel <= s;
        repeat (2) @(posedge clk);
        chk(rrd, e);
    endtask
    task wait_act(input logic [3:0] e);
        for (int i = 0; i < 400; i++) begin
            @(posedge clk);
            if (act === e && busy === 1'b0) break;
        end
        chk(act, e);
    endtask
    task exit_lvl(input logic s, input logic [1:0] l);
        @(posedge clk);
        ext <= !s;
        setl <= s;
        sl <= l;
        @(posedge clk);
        ext <= 1'b0;
        setl <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task lvx;
        exit_lvl(1'b0, 2'h0);
    endtask
    task raise(input int d);
        @(posedge clk);
        rs <= 16'(1 << d);
        @(posedge clk);
        rs <= 16'h0;
    endtask
    task cls(input logic [2:0] c);
        @(posedge clk);
        csel <= c;
        creq <= 1'b1;
        @(posedge clk);
        creq <= 1'b0;
    endtask
    task idle_chk;
        repeat (20) @(posedge clk);
        chk(act, 4'h0);
    endtask
    task t_ipl_bus;
        @(posedge clk);
        ipl <= 1'b1;
        @(posedge clk);
        ipl <= 1'b0;
        wait_act(4'h1);
        rreg(4'h9, 16'h0);
        lvx();
        chk(wt, 1'b1);
        bus(1'b0, 4'hc, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, 4'h0, 32'hf1);
        bus(1'b0, 4'h0, 32'h0);
        chk(q, 32'hf1);
    endtask
    task t_io;
        prep(8'h03, 4'h2, 1'b1);
        prep(8'h05, 4'h2, 1'b0);
        raise(5);
        raise(3);
        wait_act(4'h4);
        chk(ackd, 8'h03);
        rreg(4'h7, 16'ha503);
        rreg(4'h1, 16'h1036);
        rreg(4'h9, 16'h2036);
        bus(1'b0, 4'h4, 32'h0);
        chk(q, 32'h44);
        lvx();
        idle_chk();
        prep(8'h05, 4'h3, 1'b1);
        wait_act(4'h8);
        chk(ackd, 8'h05);
        lvx();
    endtask
    task t_preempt;
        lat <= 4'h5;
        prep(8'h01, 4'h0, 1'b1);
        raise(3);
        wait_act(4'h4);
        bnd <= 1'b0;
        raise(1);
        repeat (20) @(posedge clk);
        chk(ack, 1'b0);
        bnd <= 1'b1;
        wait_act(4'h5);
        chk(cur, 2'h0);
        raise(3);
        lvx();
        wait_act(4'h4);
        repeat (20) @(posedge clk);
        chk(ack, 1'b0);
        lvx();
        wait_act(4'h4);
        lvx();
        chk(wt, 1'b1);
    endtask
    task t_masks;
        prep(8'h06, 4'h1, 1'b1);
        bus(1'b1, 4'h0, 32'hf0);
        raise(6);
        idle_chk();
        bus(1'b1, 4'h0, 32'hd1);
        idle_chk();
        stop <= 1'b1;
        bus(1'b1, 4'h0, 32'hf1);
        idle_chk();
        stop <= 1'b0;
        wait_act(4'h2);
        lvx();
        prep(8'h07, 4'h6, 1'b1);
        raise(7);
        idle_chk();
    endtask
    task t_class;
        lat <= 4'h1;
        for (int c = 0; c < 7; c++) begin
            cls(c[2:0]);
            repeat (2) @(posedge clk);
            wait_act(4'h1);
            chk(cptr, 16'h1008 + 16'(4 * c));
            rreg(4'h9, 16'h100a + 16'(4 * c));
            lvx();
        end
        bus(1'b1, 4'h0, 32'hf0);
        cls(3'h3);
        idle_chk();
        exit_lvl(1'b1, 2'h1);
        chk(act, 4'h2);
        lvx();
        chk(wt, 1'b1);
    endtask
    initial begin
        clk = 1'b0;
        {rst_n, rd, wr, ext, setl, stop, ipl, creq, sl, csel, adr, rsel, lat, rs, wd} = '0;
        bnd = 1'b1;
        n_mismatch = 0;
        n_tests = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_ipl_bus();
        t_io();
        t_preempt();
        t_masks();
        t_class();
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end
endmodule // pliu_top_bench
